//--- pkg/exc_pkg.sv
// Shared constants, types and register map of the exception entry block
package exc_pkg;
    // Machine state bit positions (vector index, doc bit n sits at 31-n)
    localparam int unsigned BIT_EXC_ENDIAN = 16;
    localparam int unsigned BIT_PREFIX = 6;
    localparam int unsigned BIT_RECOVER = 1;
    localparam int unsigned BIT_ENDIAN = 0;
    // Implemented machine state bits; all others are reserved and held at zero
    localparam logic [31:0] STATE_IMPL_MASK = 32'h0005_FF77;
    // Bits that exception entry leaves alone (exc-endian, check enable, prefix)
    localparam logic [31:0] ENTRY_KEEP_MASK = 32'h0001_1040;
    // Machine check also clears check enable
    localparam logic [31:0] MCHECK_KEEP_MASK = 32'h0001_0040;
    // Saved status bits copied from machine state (doc bits 0, 5-9, 16-31)
    localparam logic [31:0] SAVE_COPY_MASK = 32'h87C0_FFFF;
    // Saved status bits filled with cause information (doc bits 1-4, 10-15)
    localparam logic [31:0] SAVE_CAUSE_MASK = 32'h783F_0000;
    // Vector bases and offsets
    localparam logic [31:0] VEC_BASE_HIGH = 32'hFFF0_0000;
    localparam logic [31:0] VEC_BASE_LOW = 32'h0000_0000;
    localparam logic [19:0] SYS_RESET_OFFSET = 20'h0_0100;
    localparam logic [19:0] MCHECK_OFFSET = 20'h0_0200;
    // Machine state after a hard reset
    localparam logic [31:0] STATE_RESET = 32'h0000_0000;
    // Register map, byte addresses
    localparam logic [7:0] OFF_MACHINE_STATE = 8'h00;
    localparam logic [7:0] OFF_RETURN_ADDR = 8'h04;
    localparam logic [7:0] OFF_SAVED_STATUS = 8'h08;
    localparam logic [7:0] OFF_CONFIG = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    // Config register: bit 0 is the hard reset marker
    localparam int unsigned CFG_MARKER_BIT = 0;
    // Status register fields
    localparam int unsigned STS_STATE_LSB = 0;
    localparam int unsigned STS_PEND_BIT = 2;
    localparam int unsigned STS_RESV_BIT = 3;
    localparam int unsigned STS_UNREC_BIT = 4;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_DRAIN = 2'b01,
        ST_BARRIER = 2'b10
    } state_t;

    // Exception request from the core units
    typedef struct packed {
        logic valid;
        logic mcheck;
        logic [19:0] offset;
        logic [31:0] cause;
    } exc_req_t;

    // Fetch redirect toward the fetch unit
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } redirect_t;
endpackage

//--- src/pin_sync3.sv
// Three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 (
    input wire logic mclk,
    input wire logic rst,
    input wire logic din,
    output logic level
);
    // Stage chain; first stage feeds only the second
    logic s1;
    logic s2;
    logic s3;

    // Shift the pin through three flops
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            level <= 1'b0;
        end else if (s2 == s3) begin
            level <= s3;
        end
    end
endmodule
`default_nettype wire

//--- src/exception_entry.sv
// Exception entry, system reset handling and context barriers with APB registers
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module exception_entry #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reset pins from the board, active high here
    input wire logic soft_reset_in,
    input wire logic hard_reset_in,
    // Core side
    input wire exc_pkg::exc_req_t exc_req,
    input wire logic [31:0] next_ea,
    input wire logic point_done,
    input wire logic queue_empty,
    input wire logic state_corrupt,
    input wire logic order_barrier_req,
    input wire logic fetch_barrier_req,
    input wire logic earlier_done,
    input wire logic load_reserve_exec,
    input wire logic store_cond_exec,
    output exc_pkg::redirect_t redirect,
    output logic block_completion,
    output logic hold_issue,
    output logic barrier_done,
    output logic flush_fetch,
    output logic reservation_valid,
    output logic [31:0] machine_state_reg
);
    // Architectural registers
    logic [31:0] saved_return_addr;
    logic [31:0] saved_status_word;
    logic hard_reset_marker;
    // Sequencer
    exc_pkg::state_t state;
    logic soft_pend;      // Soft reset seen, waiting to save
    logic unrecov;        // Machine check hit while draining
    logic fetch_kind;     // Barrier in progress is a fetch barrier
    // Synchronised pins and edge history
    logic soft_lvl;
    logic hard_lvl;
    logic soft_prev;
    logic hard_prev;
    logic soft_edge;
    logic hard_edge;
    // Entry selection
    logic take_mc;
    logic take_soft;
    logic take_other;
    logic entry;
    logic [19:0] entry_off;
    logic [31:0] next_state_bits;
    logic [31:0] next_status;
    logic [31:0] entry_base;
    // APB decode
    logic apb_access;
    logic apb_write;
    logic [31:0] read_mux;
    logic read_hit;

    pin_sync3 soft_sync (
        .mclk(mclk),
        .rst(rst),
        .din(soft_reset_in),
        .level(soft_lvl)
    );
    pin_sync3 hard_sync (
        .mclk(mclk),
        .rst(rst),
        .din(hard_reset_in),
        .level(hard_lvl)
    );

    // Edge history of both synchronised levels
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            soft_prev <= 1'b0;
            hard_prev <= 1'b0;
        end else begin
            soft_prev <= soft_lvl;
            hard_prev <= hard_lvl;
        end
    end

    // edge detect
    // Soft edges during a hard reset are ignored; the board must not do that anyway
    assign soft_edge = soft_lvl & ~soft_prev & ~hard_lvl;
    assign hard_edge = hard_lvl & ~hard_prev;

    // priority order
    // Hard reset first, then machine check, then soft reset, then the rest
    always_comb begin
        take_mc = exc_req.valid & exc_req.mcheck & ~hard_edge;
        take_soft = (state == exc_pkg::ST_DRAIN) & point_done & queue_empty
            & ~hard_edge & ~take_mc;
        take_other = exc_req.valid & ~exc_req.mcheck & ~hard_edge & ~take_soft;
        entry = take_mc | take_soft | take_other;
        if (take_mc) begin
            entry_off = exc_pkg::MCHECK_OFFSET;
        end else if (take_soft) begin
            entry_off = exc_pkg::SYS_RESET_OFFSET;
        end else begin
            entry_off = exc_req.offset;
        end
    end

    always_comb begin
        next_state_bits = machine_state_reg
            & (take_mc ? exc_pkg::MCHECK_KEEP_MASK : exc_pkg::ENTRY_KEEP_MASK);
        next_state_bits[exc_pkg::BIT_ENDIAN] = machine_state_reg[exc_pkg::BIT_EXC_ENDIAN];
    end

    always_comb begin
        next_status = machine_state_reg & exc_pkg::SAVE_COPY_MASK;
        if (!take_soft) begin
            next_status = next_status | (exc_req.cause & exc_pkg::SAVE_CAUSE_MASK);
        end
        if (take_soft && (state_corrupt || unrecov)) begin
            next_status[exc_pkg::BIT_RECOVER] = 1'b0;
        end
    end

    assign entry_base = machine_state_reg[exc_pkg::BIT_PREFIX]
        ? exc_pkg::VEC_BASE_HIGH : exc_pkg::VEC_BASE_LOW;

    // APB phase decode; access phase lasts two cycles
    assign apb_access = psel & penable & ~pready;
    assign apb_write = psel & penable & pready & pwrite;

    // Sequencer: run, drain for soft reset, barrier wait
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= exc_pkg::ST_RUN;
            soft_pend <= 1'b0;
            fetch_kind <= 1'b0;
        end else if (hard_edge) begin
            state <= exc_pkg::ST_RUN;
            soft_pend <= 1'b0;
            fetch_kind <= 1'b0;
        end else if (soft_edge) begin
            state <= exc_pkg::ST_DRAIN;
            soft_pend <= 1'b1;
        end else begin
            unique case (state)
                exc_pkg::ST_RUN: begin
                    // Barriers start only when nothing is being taken
                    if (!entry && (order_barrier_req || fetch_barrier_req)) begin
                        state <= exc_pkg::ST_BARRIER;
                        fetch_kind <= fetch_barrier_req;
                    end
                end
                exc_pkg::ST_DRAIN: begin
                    // Stay until the soft reset itself is saved
                    if (take_soft) begin
                        state <= exc_pkg::ST_RUN;
                        soft_pend <= 1'b0;
                    end
                end
                exc_pkg::ST_BARRIER: begin
                    // An exception cancels the wait; otherwise wait for older work
                    if (entry || earlier_done) begin
                        state <= exc_pkg::ST_RUN;
                    end
                end
                default: begin
                    state <= exc_pkg::ST_RUN;
                end
            endcase
        end
    end

    // unrecoverable flag
    // Set by a machine check while a soft reset is pending; set wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            unrecov <= 1'b0;
        end else if (hard_edge) begin
            unrecov <= 1'b0;
        end else if (take_mc && soft_pend) begin
            unrecov <= 1'b1;
        end else if (take_soft) begin
            unrecov <= 1'b0;
        end
    end

    // Machine state register: hard reset, entry, then software write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            machine_state_reg <= exc_pkg::STATE_RESET;
        end else if (hard_edge) begin
            machine_state_reg <= exc_pkg::STATE_RESET;
        end else if (entry) begin
            machine_state_reg <= next_state_bits;
        end else if (apb_write && paddr == exc_pkg::OFF_MACHINE_STATE) begin
            machine_state_reg <= pwdata & exc_pkg::STATE_IMPL_MASK;
        end
    end

    // Save/restore pair; entry beats a software write in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            saved_return_addr <= 32'h0000_0000;
            saved_status_word <= 32'h0000_0000;
        end else if (hard_edge) begin
            saved_return_addr <= 32'h0000_0000;
            saved_status_word <= 32'h0000_0000;
        end else if (entry) begin
            saved_return_addr <= next_ea;
            saved_status_word <= next_status;
        end else if (apb_write) begin
            if (paddr == exc_pkg::OFF_RETURN_ADDR) begin
                saved_return_addr <= pwdata;
            end
            if (paddr == exc_pkg::OFF_SAVED_STATUS) begin
                saved_status_word <= pwdata;
            end
        end
    end

    // marker cleared by hard reset
    // Soft reset never touches it; software sets it after boot
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hard_reset_marker <= 1'b0;
        end else if (hard_edge) begin
            hard_reset_marker <= 1'b0;
        end else if (apb_write && paddr == exc_pkg::OFF_CONFIG) begin
            hard_reset_marker <= pwdata[exc_pkg::CFG_MARKER_BIT];
        end
    end

    // Fetch redirect and flush pulses
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            redirect <= '0;
            flush_fetch <= 1'b0;
        end else if (hard_edge) begin
            redirect.valid <= 1'b1;
            redirect.addr <= (exc_pkg::STATE_RESET[exc_pkg::BIT_PREFIX]
                ? exc_pkg::VEC_BASE_HIGH : exc_pkg::VEC_BASE_LOW)
                | {12'h000, exc_pkg::SYS_RESET_OFFSET};
            flush_fetch <= 1'b1;
        end else if (entry) begin
            redirect.valid <= 1'b1;
            redirect.addr <= entry_base | {12'h000, entry_off};
            flush_fetch <= 1'b1;
        end else if (state == exc_pkg::ST_BARRIER && earlier_done && fetch_kind) begin
            redirect.valid <= 1'b1;
            redirect.addr <= next_ea;
            flush_fetch <= 1'b1;
        end else begin
            redirect.valid <= 1'b0;
            flush_fetch <= 1'b0;
        end
    end

    // Completion blocking and issue hold
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            block_completion <= 1'b0;
            hold_issue <= 1'b0;
            barrier_done <= 1'b0;
        end else begin
            block_completion <= (soft_edge | (state == exc_pkg::ST_DRAIN & ~take_soft))
                & ~hard_edge;
            hold_issue <= hard_lvl | (state == exc_pkg::ST_RUN & ~entry
                & (order_barrier_req | fetch_barrier_req))
                | (state == exc_pkg::ST_BARRIER & ~entry & ~earlier_done);
            barrier_done <= state == exc_pkg::ST_BARRIER & ~entry & earlier_done
                & ~hard_edge & ~soft_edge;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reservation_valid <= 1'b0;
        end else if (hard_edge || store_cond_exec) begin
            reservation_valid <= 1'b0;
        end else if (load_reserve_exec) begin
            reservation_valid <= 1'b1;
        end
    end

    // Register read mux; unmapped addresses answer with an error
    always_comb begin
        read_mux = 32'h0000_0000;
        read_hit = 1'b1;
        unique case (paddr)
            exc_pkg::OFF_MACHINE_STATE: read_mux = machine_state_reg;
            exc_pkg::OFF_RETURN_ADDR: read_mux = saved_return_addr;
            exc_pkg::OFF_SAVED_STATUS: read_mux = saved_status_word;
            exc_pkg::OFF_CONFIG: read_mux[exc_pkg::CFG_MARKER_BIT] = hard_reset_marker;
            exc_pkg::OFF_STATUS: begin
                read_mux[exc_pkg::STS_STATE_LSB +: 2] = state;
                read_mux[exc_pkg::STS_PEND_BIT] = soft_pend;
                read_mux[exc_pkg::STS_RESV_BIT] = reservation_valid;
                read_mux[exc_pkg::STS_UNREC_BIT] = unrecov;
            end
            default: read_hit = 1'b0;
        endcase
    end

    // APB answer: pready one cycle into the access phase
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access & ~read_hit;
            if (apb_access && !pwrite) begin
                prdata <= read_mux;
            end
        end
    end

    // Checks
    entry_clear_a: assert property (@(posedge mclk) disable iff (rst)
        entry && !take_mc |=> (machine_state_reg & ~exc_pkg::ENTRY_KEEP_MASK
            & ~(32'h0000_0001 << exc_pkg::BIT_ENDIAN)) == 32'h0000_0000)
        else $error("entry left a cleared state bit set");
    endian_copy_a: assert property (@(posedge mclk) disable iff (rst)
        entry |=> machine_state_reg[exc_pkg::BIT_ENDIAN]
            == $past(machine_state_reg[exc_pkg::BIT_EXC_ENDIAN]))
        else $error("endian mode not copied on entry");
    state_reserved_a: assert property (@(posedge mclk) disable iff (rst)
        (machine_state_reg & ~exc_pkg::STATE_IMPL_MASK) == 32'h0000_0000)
        else $error("reserved state bit set");
    vector_base_a: assert property (@(posedge mclk) disable iff (rst)
        entry && !hard_edge |=> redirect.valid && redirect.addr[31:20]
            == ($past(machine_state_reg[exc_pkg::BIT_PREFIX]) ? 12'hFFF : 12'h000))
        else $error("vector base does not follow prefix");
    reset_vector_a: assert property (@(posedge mclk) disable iff (rst)
        take_soft || hard_edge |=> redirect.valid
            && redirect.addr[19:0] == exc_pkg::SYS_RESET_OFFSET)
        else $error("reset not vectored to reset offset");
    save_return_a: assert property (@(posedge mclk) disable iff (rst)
        take_soft |=> saved_return_addr == $past(next_ea))
        else $error("return address not saved");
    status_save_a: assert property (@(posedge mclk) disable iff (rst)
        take_soft |=> (saved_status_word & exc_pkg::SAVE_CAUSE_MASK) == 32'h0000_0000
            && (saved_status_word[31:2] == $past(machine_state_reg[31:2]
            & exc_pkg::SAVE_COPY_MASK[31:2])))
        else $error("saved status wrong after soft reset");
    drain_block_a: assert property (@(posedge mclk) disable iff (rst)
        soft_edge ##1 (state == exc_pkg::ST_DRAIN && !take_soft && !hard_edge)
            |=> block_completion)
        else $error("completion not blocked while draining");
    marker_clear_a: assert property (@(posedge mclk) disable iff (rst)
        hard_edge |=> !hard_reset_marker [*2])
        else $error("marker survived hard reset");
    barrier_hold_a: assert property (@(posedge mclk) disable iff (rst)
        state == exc_pkg::ST_BARRIER && !entry && !earlier_done |=> hold_issue && !barrier_done)
        else $error("barrier released before earlier work done");
    resv_clear_a: assert property (@(posedge mclk) disable iff (rst)
        store_cond_exec |=> !reservation_valid)
        else $error("reservation survived store-conditional");
    soft_once_a: assert property (@(posedge mclk) disable iff (rst)
        take_soft && !soft_edge |=> !take_soft)
        else $error("two reset exceptions for one edge");

    soft_reset_c: cover property (@(posedge mclk) disable iff (rst)
        soft_edge ##[1:20] take_soft);
    mcheck_drain_c: cover property (@(posedge mclk) disable iff (rst)
        take_mc && soft_pend);
    fetch_barrier_c: cover property (@(posedge mclk) disable iff (rst)
        state == exc_pkg::ST_BARRIER && fetch_kind && earlier_done);
endmodule
`default_nettype wire

//--- dv/board_reset_model.sv
// Board-side model that drives the soft and hard reset pins
`timescale 1ns/10ps
`default_nettype none
module board_reset_model (
    input wire logic mclk,
    output logic soft_reset_in,
    output logic hard_reset_in
);
    // power-up hold
    // Hard reset stays up well past the pin synchroniser at power-up
    initial begin
        soft_reset_in = 1'b0;
        hard_reset_in = 1'b1;
        repeat (8) @(posedge mclk);
        hard_reset_in <= 1'b0;
    end
    // no overlap
    // A soft pulse waits for hard reset to clear, else the core is undefined
    task automatic pulse_soft(input int cycles);
        while (hard_reset_in !== 1'b0) @(posedge mclk);
        @(posedge mclk);
        soft_reset_in <= 1'b1;
        repeat (cycles) @(posedge mclk);
        soft_reset_in <= 1'b0;
    endtask
    task automatic pulse_hard(input int cycles);
        @(posedge mclk);
        hard_reset_in <= 1'b1;
        repeat (cycles) @(posedge mclk);
        hard_reset_in <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- dv/exception_entry_tb.sv
// Self-checking bench for the exception entry block
`timescale 1ns/10ps
`default_nettype none
module exception_entry_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic soft_reset_in, hard_reset_in, block_completion, hold_issue;
    logic barrier_done, flush_fetch, reservation_valid;
    logic [31:0] machine_state_reg, next_ea = 32'h0000_0000;
    // Core-side stimulus, all held low until a scenario raises them
    logic point_done = 1'b0, queue_empty = 1'b0, state_corrupt = 1'b0;
    logic order_barrier_req = 1'b0, fetch_barrier_req = 1'b0, earlier_done = 1'b0;
    logic load_reserve_exec = 1'b0, store_cond_exec = 1'b0;
    exc_pkg::exc_req_t exc_req = '0;
    exc_pkg::redirect_t redirect;
    int err_total = 0, checked = 0;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_t;
    // Address, write data, expected read-back; 0x20 is unmapped
    row_t rows [5] = '{'{8'h00, 32'hFFFF_FFFF, exc_pkg::STATE_IMPL_MASK},
        '{8'h04, 32'h1234_5678, 32'h1234_5678}, '{8'h08, 32'h8765_4321, 32'h8765_4321},
        '{8'h0C, 32'h0000_0001, 32'h0000_0001}, '{8'h20, 32'hFFFF_FFFF, 32'h0000_0000}};

    always #5 mclk = ~mclk;

    board_reset_model board (.mclk, .soft_reset_in, .hard_reset_in);
    exception_entry dut (.mclk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .soft_reset_in, .hard_reset_in, .exc_req, .next_ea, .point_done,
        .queue_empty, .state_corrupt, .order_barrier_req, .fetch_barrier_req, .earlier_done,
        .load_reserve_exec, .store_cond_exec, .redirect, .block_completion, .hold_issue,
        .barrier_done, .flush_fetch, .reservation_valid, .machine_state_reg);

    task automatic give_verdict();
        if (err_total == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // A slave that never answers is a failure, not a silent pass
        if (pready !== 1'b1) err_total++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Bounded wait: 0 redirect, 1 block, 2 hold, 3 barrier done
    task automatic wait_on(input int k);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (((k == 0) ? redirect.valid : (k == 1) ? block_completion :
                    (k == 2) ? hold_issue : barrier_done) !== 1'b1 && n < 100);
        chk(32'(n < 100), 32'h0000_0001);
    endtask

    // Watchdog well past the expected few hundred cycles
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (20) @(posedge mclk);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w, rd, err);
            apb(1'b0, rows[i].a, 32'h0000_0000, rd, err);
            chk(rd, rows[i].e);
            chk({31'b0, err}, {31'b0, rows[i].a == 8'h20});
        end
        next_ea <= 32'h0000_4440;
        exc_req <= '{1'b1, 1'b0, 20'h0_0700, 32'hFFFF_FFFF};
        @(posedge mclk);
        exc_req <= '0;
        #1;
        chk({31'b0, redirect.valid}, 32'h0000_0001);
        chk(redirect.addr, 32'hFFF0_0700);
        chk(machine_state_reg, (exc_pkg::STATE_IMPL_MASK & exc_pkg::ENTRY_KEEP_MASK) | 1);
        apb(1'b0, 8'h08, 32'h0000_0000, rd, err);
        chk(rd, (exc_pkg::STATE_IMPL_MASK & exc_pkg::SAVE_COPY_MASK) | exc_pkg::SAVE_CAUSE_MASK);
        apb(1'b0, 8'h04, 32'h0000_0000, rd, err);
        chk(rd, 32'h0000_4440);
        next_ea <= 32'h0000_5550;
        board.pulse_soft(5);
        wait_on(1);
        point_done <= 1'b1;
        queue_empty <= 1'b1;
        wait_on(0);
        chk(redirect.addr, 32'hFFF0_0100);
        chk({31'b0, block_completion}, 32'h0000_0000);
        point_done <= 1'b0;
        queue_empty <= 1'b0;
        apb(1'b0, 8'h0C, 32'h0000_0000, rd, err);
        chk(rd, 32'h0000_0001);
        apb(1'b0, 8'h04, 32'h0000_0000, rd, err);
        chk(rd, 32'h0000_5550);
        fork
            board.pulse_hard(6);
            wait_on(0);
        join
        chk(redirect.addr, 32'h0000_0100);
        chk(machine_state_reg, 32'h0000_0000);
        repeat (8) @(posedge mclk);
        apb(1'b0, 8'h0C, 32'h0000_0000, rd, err);
        chk(rd, 32'h0000_0000);
        // Ordering barrier first, then fetch barrier
        for (int k = 0; k < 2; k++) begin
            order_barrier_req <= (k == 0);
            fetch_barrier_req <= (k == 1);
            next_ea <= 32'h0000_6660;
            wait_on(2);
            order_barrier_req <= 1'b0;
            fetch_barrier_req <= 1'b0;
            chk({31'b0, barrier_done}, 32'h0000_0000);
            earlier_done <= 1'b1;
            wait_on(3);
            earlier_done <= 1'b0;
            chk({31'b0, flush_fetch}, 32'(k));
            chk({31'b0, hold_issue}, 32'h0000_0000);
            if (k == 1) chk(redirect.addr, 32'h0000_6660);
        end
        @(posedge mclk);
        load_reserve_exec <= 1'b1;
        @(posedge mclk);
        load_reserve_exec <= 1'b0;
        @(posedge mclk);
        #1;
        chk({31'b0, reservation_valid}, 32'h0000_0001);
        store_cond_exec <= 1'b1;
        @(posedge mclk);
        store_cond_exec <= 1'b0;
        @(posedge mclk);
        #1;
        chk({31'b0, reservation_valid}, 32'h0000_0000);
        // soft reset with corrupt state, check in drain, then clean
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, 8'h00, 32'h0000_0002, rd, err);
            board.pulse_soft(5);
            wait_on(1);
            if (k == 1) begin
                exc_req <= '{1'b1, 1'b1, 20'h0_0000, 32'h0000_0000};
                @(posedge mclk);
                exc_req <= '0;
                #1;
                chk(redirect.addr, 32'h0000_0200);
                apb(1'b1, 8'h00, 32'h0000_0002, rd, err);
                apb(1'b0, 8'h10, 32'h0000_0000, rd, err);
                chk(rd, 32'h0000_0015);
            end
            state_corrupt <= (k == 0);
            point_done <= 1'b1;
            queue_empty <= 1'b1;
            wait_on(0);
            chk(redirect.addr, 32'h0000_0100);
            state_corrupt <= 1'b0;
            point_done <= 1'b0;
            queue_empty <= 1'b0;
            apb(1'b0, 8'h08, 32'h0000_0000, rd, err);
            chk(rd, (k == 2) ? 32'h0000_0002 : 32'h0000_0000);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
